// >>> hw/scrt_ctrl.sv
`timescale 1ns/1ns
`default_nettype none
`include "scrt_params.svh"
module scrt_ctrl (
  input  wire logic [7:0]        ctrl,        // Control register
  output scrt_pkg::scrt_half_t   low_half,    // Low half or whole timer controls
  output scrt_pkg::scrt_half_t   high_half,   // High half controls
  output logic                   split,       // Split configuration
  output logic                   irq          // Interrupt request
);
  import scrt_pkg::*;
  // Mode decoding of control bits
  always_comb begin
    split         = ctrl[`SCRT_BIT_SPLIT];
    low_half.run  = ctrl[`SCRT_BIT_LRUN];
    low_half.cap  = ctrl[`SCRT_BIT_LCAP];
    high_half.run = split & ctrl[`SCRT_BIT_HRUN];
    high_half.cap = split & ctrl[`SCRT_BIT_HCAP];
    irq = ctrl[`SCRT_BIT_HFLAG] | (ctrl[`SCRT_BIT_LFLAG] & ctrl[`SCRT_BIT_LIRQ_EN]);
  end
endmodule : scrt_ctrl
`default_nettype wire

// >>> hw/scrt_half.sv
`timescale 1ns/1ns
`default_nettype none
module scrt_half #(
  parameter int WIDTH = 8
) (
  input  wire logic [WIDTH-1:0] count,       // Present count
  input  wire logic [WIDTH-1:0] reload,      // Reload value
  input  wire logic             inc,         // Count this cycle
  output logic [WIDTH-1:0]      next_count,  // Count after increment or reload
  output logic                  ovf          // Overflow this cycle
);
  // Increment with reload on wrap
  always_comb begin
    ovf        = inc & (&count);
    next_count = count;
    if (ovf) begin
      next_count = reload;
    end else if (inc) begin
      next_count = count + WIDTH'(1);
    end
  end
endmodule : scrt_half
`default_nettype wire

// >>> hw/scrt_params.svh
// Notes on behaviour
// - Bit 5 enables low flag onto interrupt
// - Request is high flag OR masked low flag
// - Split bit 0: one 16-bit counter
// - Split bit 1: two independent 8-bit halves
// - Bit 3 captures high half, split only
// - Bit 2 captures low half or whole
// - Bit 1 runs high half in split
// - Bit 0 runs low half or whole
// - Low reload byte at address BA
// - High reload byte at address BB
// - Reload bytes unbuffered, effective next cycle
// - Capture mode latches count into reload
// - Timer mode reloads counter from reload
// - High flag set on overflow/capture, sticky
// - Low flag set on low overflow/capture, sticky
// - Wide capture: capture high, overflow low
// - Count registers live, readable and writable
`ifndef SCRT_PARAMS_SVH
`define SCRT_PARAMS_SVH
`define SCRT_ADDR_CTRL     8'hB9
`define SCRT_ADDR_RELOAD_L 8'hBA
`define SCRT_ADDR_RELOAD_H 8'hBB
`define SCRT_ADDR_COUNT_L  8'hBC
`define SCRT_ADDR_COUNT_H  8'hBD
`define SCRT_BIT_HFLAG     7
`define SCRT_BIT_LFLAG     6
`define SCRT_BIT_LIRQ_EN   5
`define SCRT_BIT_SPLIT     4
`define SCRT_BIT_HCAP      3
`define SCRT_BIT_LCAP      2
`define SCRT_BIT_HRUN      1
`define SCRT_BIT_LRUN      0
`define SCRT_RESET_BYTE    8'h00
`endif

// >>> hw/scrt_pkg.sv
package scrt_pkg;
  // Special-function register access from the core
  typedef struct packed {
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } scrt_sfr_t;
  // Per-half controls after mode decoding
  typedef struct packed {
    logic run;
    logic cap;
  } scrt_half_t;
endpackage : scrt_pkg

// >>> hw/scrt_timer.sv
`timescale 1ns/1ns
`default_nettype none
`include "scrt_params.svh"
module scrt_timer (
  input  wire logic               clk,       // 50 MHz system clock
  input  wire logic               resetn,    // Asynchronous reset, active low
  input  wire scrt_pkg::scrt_sfr_t sfr,      // Register write port
  input  wire logic [7:0]         rd_addr,   // Register read address
  output logic [7:0]              rd_data,   // Register read data
  input  wire logic               tick,      // Count enable pulse
  input  wire logic               capture,   // Capture event pulse
  output logic                    irq        // Timer interrupt request
);
  import scrt_pkg::*;

  logic [7:0] ctrl, reload_low_byte, reload_high_byte, count_low_byte, count_high_byte;
  logic [7:0] next_ctrl, next_rl, next_rh, next_cl, next_ch;
  scrt_half_t low_half, high_half;
  logic       split;
  logic [7:0] low_nc, high_nc, wide_hi_nc;
  logic       low_ovf, high_ovf, wide_hi_ovf;
  logic       low_inc, high_inc, wide_hi_inc;

  // Control decode and interrupt combination
  scrt_ctrl u_ctrl (
    .ctrl      (ctrl),
    .low_half  (low_half),
    .high_half (high_half),
    .split     (split),
    .irq       (irq)
  );

  // Increment enables for each mode
  always_comb begin
    low_inc     = tick & low_half.run & ~(low_half.cap & split);
    high_inc    = tick & high_half.run & ~high_half.cap;
    wide_hi_inc = tick & low_half.run & (&count_low_byte);
  end

  // Low half counter; in wide mode only its wrap flag is used
  scrt_half #(.WIDTH(8)) u_low (
    .count      (count_low_byte),
    .reload     (reload_low_byte),
    .inc        (low_inc),
    .next_count (low_nc),
    .ovf        (low_ovf)
  );

  // High half counter in split mode
  scrt_half #(.WIDTH(8)) u_high (
    .count      (count_high_byte),
    .reload     (reload_high_byte),
    .inc        (high_inc),
    .next_count (high_nc),
    .ovf        (high_ovf)
  );

  // High byte of wide counter, carried from low byte
  scrt_half #(.WIDTH(8)) u_wide (
    .count      (count_high_byte),
    .reload     (reload_high_byte),
    .inc        (wide_hi_inc),
    .next_count (wide_hi_nc),
    .ovf        (wide_hi_ovf)
  );

  // Next-state for counters, reload bytes and flags
  always_comb begin
    logic set_h;
    logic set_l;
    set_h     = 1'b0;
    set_l     = 1'b0;
    next_ctrl = ctrl;
    next_rl   = reload_low_byte;
    next_rh   = reload_high_byte;
    next_cl   = count_low_byte;
    next_ch   = count_high_byte;
    if (split) begin
      next_cl = low_nc;
      next_ch = high_nc;
      set_l   = low_ovf;
      set_h   = high_ovf;
      if (low_half.cap && capture) begin
        next_rl = count_low_byte;
        set_l   = 1'b1;
      end
      if (high_half.cap && capture) begin
        next_rh = count_high_byte;
        set_h   = 1'b1;
      end
    end else if (low_half.cap) begin
      // Wide capture: free-running, overflow marks the extra bit
      if (tick && low_half.run) begin
        next_cl = count_low_byte + 8'h01;
        next_ch = (&count_low_byte) ? count_high_byte + 8'h01 : count_high_byte;
      end
      set_l = wide_hi_ovf;
      if (capture) begin
        next_rl = count_low_byte;
        next_rh = count_high_byte;
        set_h   = 1'b1;
      end
    end else begin
      // Low byte wraps to zero and carries; only the 16-bit wrap reloads
      next_cl = low_inc ? count_low_byte + 8'h01 : count_low_byte;
      set_l   = low_ovf;
      if (wide_hi_ovf) begin
        next_cl = reload_low_byte;
        next_ch = reload_high_byte;
        set_h   = 1'b1;
      end else begin
        next_ch = wide_hi_nc;
      end
    end
    // Software writes; flag set wins over clear
    if (sfr.wr) begin
      case (sfr.addr)
        `SCRT_ADDR_CTRL:     next_ctrl = sfr.wdata;
        `SCRT_ADDR_RELOAD_L: next_rl   = sfr.wdata;
        `SCRT_ADDR_RELOAD_H: next_rh   = sfr.wdata;
        `SCRT_ADDR_COUNT_L:  next_cl   = sfr.wdata;
        `SCRT_ADDR_COUNT_H:  next_ch   = sfr.wdata;
        default: ;
      endcase
    end
    if (set_h) next_ctrl[`SCRT_BIT_HFLAG] = 1'b1;
    if (set_l) next_ctrl[`SCRT_BIT_LFLAG] = 1'b1;
  end

  // Register stage, all cleared on reset
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ctrl             <= `SCRT_RESET_BYTE;
      reload_low_byte  <= `SCRT_RESET_BYTE;
      reload_high_byte <= `SCRT_RESET_BYTE;
      count_low_byte   <= `SCRT_RESET_BYTE;
      count_high_byte  <= `SCRT_RESET_BYTE;
    end else begin
      ctrl             <= next_ctrl;
      reload_low_byte  <= next_rl;
      reload_high_byte <= next_rh;
      count_low_byte   <= next_cl;
      count_high_byte  <= next_ch;
    end
  end

  // Read multiplexer, unmapped reads zero
  always_comb begin
    case (rd_addr)
      `SCRT_ADDR_CTRL:     rd_data = ctrl;
      `SCRT_ADDR_RELOAD_L: rd_data = reload_low_byte;
      `SCRT_ADDR_RELOAD_H: rd_data = reload_high_byte;
      `SCRT_ADDR_COUNT_L:  rd_data = count_low_byte;
      `SCRT_ADDR_COUNT_H:  rd_data = count_high_byte;
      default:             rd_data = 8'h00;
    endcase
  end

  property p_irq_mask;
    @(posedge clk) disable iff (!resetn)
      irq == (ctrl[`SCRT_BIT_HFLAG] | (ctrl[`SCRT_BIT_LFLAG] & ctrl[`SCRT_BIT_LIRQ_EN]));
  endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("irq mismatch");

  property p_lirq_gate;
    @(posedge clk) disable iff (!resetn)
      !ctrl[`SCRT_BIT_LIRQ_EN] && !ctrl[`SCRT_BIT_HFLAG] |-> !irq;
  endproperty
  a_lirq_gate: assert property (p_lirq_gate) else $error("low flag not masked");

  property p_reload_write;
    @(posedge clk) disable iff (!resetn)
      sfr.wr && sfr.addr == `SCRT_ADDR_RELOAD_L && !capture |=> reload_low_byte == $past(sfr.wdata);
  endproperty
  a_reload_write: assert property (p_reload_write) else $error("reload low write lost");

  property p_reloadh_write;
    @(posedge clk) disable iff (!resetn)
      sfr.wr && sfr.addr == `SCRT_ADDR_RELOAD_H && !capture |=> reload_high_byte == $past(sfr.wdata);
  endproperty
  a_reloadh_write: assert property (p_reloadh_write) else $error("reload high write lost");

  property p_hflag_sticky;
    @(posedge clk) disable iff (!resetn)
      ctrl[`SCRT_BIT_HFLAG] && !sfr.wr |=> ctrl[`SCRT_BIT_HFLAG];
  endproperty
  a_hflag_sticky: assert property (p_hflag_sticky) else $error("high flag cleared by hw");

  property p_lflag_sticky;
    @(posedge clk) disable iff (!resetn)
      ctrl[`SCRT_BIT_LFLAG] && !sfr.wr |=> ctrl[`SCRT_BIT_LFLAG];
  endproperty
  a_lflag_sticky: assert property (p_lflag_sticky) else $error("low flag cleared by hw");

  property p_wide_capture;
    @(posedge clk) disable iff (!resetn)
      !split && low_half.cap && capture && !sfr.wr |=> ctrl[`SCRT_BIT_HFLAG]
        && {reload_high_byte, reload_low_byte} == $past({count_high_byte, count_low_byte});
  endproperty
  a_wide_capture: assert property (p_wide_capture) else $error("wide capture wrong");

  property p_split_reload;
    @(posedge clk) disable iff (!resetn)
      split && low_half.run && !low_half.cap && tick && count_low_byte == 8'hFF && !sfr.wr
        |=> count_low_byte == $past(reload_low_byte) && ctrl[`SCRT_BIT_LFLAG];
  endproperty
  a_split_reload: assert property (p_split_reload) else $error("split reload wrong");

  property p_high_ignored;
    @(posedge clk) disable iff (!resetn)
      !split && !low_half.run && !sfr.wr |=> $stable(count_high_byte);
  endproperty
  a_high_ignored: assert property (p_high_ignored) else $error("high run acted in wide");

  property p_wide_carry;
    @(posedge clk) disable iff (!resetn)
      !split && !low_half.cap && low_half.run && tick && count_low_byte == 8'hFF
        && count_high_byte != 8'hFF && !sfr.wr
        |=> count_low_byte == 8'h00 && count_high_byte == $past(count_high_byte) + 8'h01
        && ctrl[`SCRT_BIT_LFLAG];
  endproperty
  a_wide_carry: assert property (p_wide_carry) else $error("wide carry wrong");

  property p_wide_reload;
    @(posedge clk) disable iff (!resetn)
      !split && !low_half.cap && low_half.run && tick
        && {count_high_byte, count_low_byte} == 16'hFFFF && !sfr.wr
        |=> {count_high_byte, count_low_byte} == $past({reload_high_byte, reload_low_byte})
        && ctrl[`SCRT_BIT_HFLAG] && ctrl[`SCRT_BIT_LFLAG];
  endproperty
  a_wide_reload: assert property (p_wide_reload) else $error("wide reload wrong");

  property p_split_high_reload;
    @(posedge clk) disable iff (!resetn)
      split && high_half.run && !high_half.cap && tick && count_high_byte == 8'hFF && !sfr.wr
        |=> count_high_byte == $past(reload_high_byte) && ctrl[`SCRT_BIT_HFLAG];
  endproperty
  a_split_high_reload: assert property (p_split_high_reload) else $error("split high reload wrong");

  property p_split_high_hold;
    @(posedge clk) disable iff (!resetn)
      split && !high_half.run && !sfr.wr |=> $stable(count_high_byte);
  endproperty
  a_split_high_hold: assert property (p_split_high_hold) else $error("stopped high half moved");

  property p_split_low_hold;
    @(posedge clk) disable iff (!resetn)
      split && !low_half.run && !sfr.wr |=> $stable(count_low_byte);
  endproperty
  a_split_low_hold: assert property (p_split_low_hold) else $error("stopped low half moved");

  property p_split_cap_hold;
    @(posedge clk) disable iff (!resetn)
      split && low_half.cap && !sfr.wr |=> $stable(count_low_byte);
  endproperty
  a_split_cap_hold: assert property (p_split_cap_hold) else $error("capture half counted");

  property p_split_low_capture;
    @(posedge clk) disable iff (!resetn)
      split && low_half.cap && capture && !sfr.wr
        |=> reload_low_byte == $past(count_low_byte) && ctrl[`SCRT_BIT_LFLAG];
  endproperty
  a_split_low_capture: assert property (p_split_low_capture) else $error("split low capture wrong");

  property p_split_high_capture;
    @(posedge clk) disable iff (!resetn)
      split && high_half.cap && capture && !sfr.wr
        |=> reload_high_byte == $past(count_high_byte) && ctrl[`SCRT_BIT_HFLAG];
  endproperty
  a_split_high_capture: assert property (p_split_high_capture) else $error("split high capture wrong");

  property p_wide_hcap_ignored;
    @(posedge clk) disable iff (!resetn)
      !split && !low_half.cap && capture && !sfr.wr
        |=> $stable(reload_low_byte) && $stable(reload_high_byte);
  endproperty
  a_wide_hcap_ignored: assert property (p_wide_hcap_ignored) else $error("capture acted in wide timer");

  property p_wide_cap_overflow;
    @(posedge clk) disable iff (!resetn)
      !split && low_half.cap && low_half.run && tick
        && {count_high_byte, count_low_byte} == 16'hFFFF && !sfr.wr
        |=> ctrl[`SCRT_BIT_LFLAG] && count_low_byte == 8'h00 && count_high_byte == 8'h00;
  endproperty
  a_wide_cap_overflow: assert property (p_wide_cap_overflow) else $error("wide capture wrap wrong");

  property p_count_write;
    @(posedge clk) disable iff (!resetn)
      sfr.wr && sfr.addr == `SCRT_ADDR_COUNT_L |=> count_low_byte == $past(sfr.wdata);
  endproperty
  a_count_write: assert property (p_count_write) else $error("count low write lost");

  property p_count_h_write;
    @(posedge clk) disable iff (!resetn)
      sfr.wr && sfr.addr == `SCRT_ADDR_COUNT_H |=> count_high_byte == $past(sfr.wdata);
  endproperty
  a_count_h_write: assert property (p_count_h_write) else $error("count high write lost");

  property p_flag_set_wins;
    @(posedge clk) disable iff (!resetn)
      sfr.wr && sfr.addr == `SCRT_ADDR_CTRL && !split && low_half.cap && capture
        |=> ctrl[`SCRT_BIT_HFLAG];
  endproperty
  a_flag_set_wins: assert property (p_flag_set_wins) else $error("flag clear beat capture");

  // Reset has no disable here: it checks the state that reset leaves
  property p_reset_clear;
    @(posedge clk)
      $rose(resetn) |-> ctrl == `SCRT_RESET_BYTE && reload_low_byte == `SCRT_RESET_BYTE
        && reload_high_byte == `SCRT_RESET_BYTE && count_low_byte == `SCRT_RESET_BYTE
        && count_high_byte == `SCRT_RESET_BYTE;
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("register not cleared by reset");

  property p_irq_low_enabled;
    @(posedge clk) disable iff (!resetn)
      ctrl[`SCRT_BIT_LFLAG] && ctrl[`SCRT_BIT_LIRQ_EN] |-> irq;
  endproperty
  a_irq_low_enabled: assert property (p_irq_low_enabled) else $error("enabled low flag gave no irq");

  property p_irq_high_unmasked;
    @(posedge clk) disable iff (!resetn)
      ctrl[`SCRT_BIT_HFLAG] |-> irq;
  endproperty
  a_irq_high_unmasked: assert property (p_irq_high_unmasked) else $error("high flag gave no irq");
endmodule : scrt_timer
`default_nettype wire

// >>> tb/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
  import scrt_pkg::*;
  typedef struct packed {
    logic       is_irq;
    logic [7:0] val;
  } scrt_note_t;
  logic        clk;
  logic        resetn;
  scrt_sfr_t   sfr;
  logic [7:0]  rd_addr;
  logic [7:0]  rd_data;
  logic        tick;
  logic        capture;
  logic        irq;
  logic        rd_req;
  scrt_note_t  notes[$];
  scrt_note_t  nt;
  int          err_total;
  int          total_checks;
  int          cyc;
  int          seed;
  logic [15:0] v;
  logic [7:0]  rl;
  logic [7:0]  rh;
  logic [31:0] ctl_tab;
  logic [3:0]  irq_tab;

  scrt_timer dut_u (
    .clk     (clk),
    .resetn  (resetn),
    .sfr     (sfr),
    .rd_addr (rd_addr),
    .rd_data (rd_data),
    .tick    (tick),
    .capture (capture),
    .irq     (irq)
  );

  // Free-running 50 MHz clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // One register write, driven off the falling edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    sfr = '{1'b1, a, d};
    @(negedge clk);
    sfr.wr = 1'b0;
  endtask : wr

  // Note an expected read value, then present the read for one cycle
  task automatic chk(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk);
    rd_addr = a;
    rd_req = 1'b1;
    notes.push_back({1'b0, e});
    @(negedge clk);
    rd_req = 1'b0;
  endtask : chk

  // Note an expected interrupt level
  task automatic chk_irq(input logic e);
    @(negedge clk);
    rd_req = 1'b1;
    notes.push_back({1'b1, 7'h00, e});
    @(negedge clk);
    rd_req = 1'b0;
  endtask : chk_irq

  // Single-cycle pulses on the event inputs
  task automatic ticks(input int n);
    repeat (n) begin
      @(negedge clk);
      tick = 1'b1;
      @(negedge clk);
      tick = 1'b0;
    end
  endtask : ticks

  task automatic cap();
    @(negedge clk);
    capture = 1'b1;
    @(negedge clk);
    capture = 1'b0;
  endtask : cap

  task automatic cmp_data(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: read %h expected %h", $time, got, exp);
    end
  endtask : cmp_data

  task automatic cmp_irq(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: irq %h expected %h", $time, got, exp);
    end
  endtask : cmp_irq

  task automatic test_done();
    $display("Checks %0d, mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : test_done

  // Oldest note is compared whenever a result is presented
  always @(posedge clk) begin
    if (rd_req === 1'b1) begin
      nt = notes.pop_front();
      if (nt.is_irq) cmp_irq(irq, nt.val[0]);
      else cmp_data(rd_data, nt.val);
    end
  end

  // Hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_total++;
      test_done();
    end
  end

  // Main sequence
  initial begin
    sfr = '0; rd_addr = 8'h00; rd_req = 1'b0; tick = 1'b0; capture = 1'b0;
    err_total = 0; total_checks = 0; cyc = 0; seed = 62; resetn = 1'b0;
    ctl_tab = 32'h80604000; irq_tab = 4'b1100;
    repeat (8) @(posedge clk);
    @(negedge clk);
    resetn = 1'b1;
    for (int a = 8'hB9; a <= 8'hBD; a++) chk(a[7:0], 8'h00);
    chk_irq(1'b0);
    rl = 8'($random(seed));
    rh = 8'($random(seed));
    wr(8'hBA, rl); chk(8'hBA, rl);
    wr(8'hBB, rh); chk(8'hBB, rh);
    wr(8'hBE, 8'h5A); chk(8'hBE, 8'h00);
    // Wide timer: 16-bit wrap reloads both bytes and sets both flags
    wr(8'hBC, 8'hFE); wr(8'hBD, 8'hFF); chk(8'hBD, 8'hFF);
    wr(8'hB9, 8'h01); ticks(1); chk(8'hBC, 8'hFF); chk(8'hB9, 8'h01);
    ticks(1); chk(8'hBC, rl); chk(8'hBD, rh);
    chk(8'hB9, 8'hC1); chk_irq(1'b1);
    // Interrupt masking across flag and enable combinations
    for (int i = 0; i < 4; i++) begin
      wr(8'hB9, ctl_tab[8*i+:8]); chk_irq(irq_tab[i]);
    end
    // Wide low-byte wrap alone sets only the low flag
    wr(8'hB9, 8'h01); wr(8'hBC, 8'hFF); wr(8'hBD, 8'h00); ticks(1);
    chk(8'hBC, 8'h00); chk(8'hBD, 8'h01); chk(8'hB9, 8'h41);
    // High run alone does not move the wide timer
    wr(8'hB9, 8'h02); wr(8'hBC, 8'h10); ticks(2); chk(8'hBC, 8'h10);
    // Wide capture latches the whole count and sets the high flag
    v = 16'($random(seed));
    wr(8'hB9, 8'h05); wr(8'hBC, v[7:0]); wr(8'hBD, v[15:8]); cap();
    chk(8'hBA, v[7:0]); chk(8'hBB, v[15:8]); chk(8'hB9, 8'h85);
    wr(8'hBC, 8'hFF); wr(8'hBD, 8'hFF); ticks(1); chk(8'hB9, 8'hC5);
    // Flag clear written in the capture cycle: the capture's set wins
    @(negedge clk);
    sfr = '{1'b1, 8'hB9, 8'h05};
    capture = 1'b1;
    @(negedge clk);
    sfr.wr = 1'b0;
    capture = 1'b0;
    chk(8'hB9, 8'h85); chk(8'hBA, 8'h00); chk(8'hBB, 8'h00);
    // High capture select is ignored in wide configuration
    wr(8'hB9, 8'h09); wr(8'hBC, 8'h33); cap();
    chk(8'hBA, 8'h00); chk(8'hB9, 8'h09);
    // Split: low wraps to its reload while high counts on its own
    wr(8'hBA, rl); wr(8'hBB, rh); wr(8'hB9, 8'h13);
    wr(8'hBC, 8'hFF); wr(8'hBD, 8'h20); ticks(1);
    chk(8'hBC, rl); chk(8'hBD, 8'h21); chk(8'hB9, 8'h53);
    // Split high capture touches only the high reload byte
    wr(8'hB9, 8'h1B); wr(8'hBD, 8'h44); cap();
    chk(8'hBB, 8'h44); chk(8'hBA, rl); chk(8'hB9, 8'h9B);
    // Split high overflow with the low half stopped
    wr(8'hBB, rh); wr(8'hB9, 8'h12); wr(8'hBC, 8'h07); wr(8'hBD, 8'hFF); ticks(1);
    chk(8'hBD, rh); chk(8'hBC, 8'h07); chk(8'hB9, 8'h92);
    // Split low capture: the capturing half holds, latches and sets its flag
    wr(8'hB9, 8'h15); wr(8'hBC, 8'h5C); ticks(1); cap();
    chk(8'hBC, 8'h5C); chk(8'hBA, 8'h5C); chk(8'hBB, rh); chk(8'hB9, 8'h55);
    chk_irq(1'b0);
    wr(8'hB9, 8'h75); chk_irq(1'b1);
    // Mid-run reset returns every register to zero
    @(negedge clk);
    resetn = 1'b0;
    repeat (2) @(negedge clk);
    resetn = 1'b1;
    for (int a = 8'hB9; a <= 8'hBD; a++) chk(a[7:0], 8'h00);
    chk_irq(1'b0);
    test_done();
  end
endmodule : tb
`default_nettype wire
